//--- cctmr_timer.sv
// How it works
// R1: sixteen-bit up-counter, free-running or wrapping at modulo value
// R2: modulo value comes from high and low modulo registers
// R3: counter reads never disturb the counting sequence
// R4: four channels, each independently capture or compare
// R5: prescale select picks seven bus rates or external clock pin
// R6: prescale code zero counts at full bus clock rate
// R7: active capture edge copies counter into channel value registers
// R8: capture edge selectable per channel: rising, falling or any
// R9: capture event raises interrupt when channel interrupt enabled
// R10: compare match sets, clears or toggles channel pin as configured
// R11: compare match raises interrupt when channel interrupt enabled
// R12: unbuffered writes replace compare value immediately
// R13: software writes smaller values at compare, larger at overflow
// R14: pair01 buffer select links channels 0 and 1 onto pin 0
// R15: writing second channel hands it control after next overflow
// R16: each overflow gives control to most recently written channel
// R17: while linked, channel 1 control unused and pin freed
// R18: pair23 buffer select links channels 2 and 3 likewise
// R19: software avoids writing the active channel of a pair
// R20: toggle-on-overflow toggles pin when counter reaches modulo
// R21: software picks clear on compare for high-polarity pulses
// R22: software never toggles on compare for pwm
// R23: overflow flag set at modulo, gated by overflow interrupt enable; the flag sets regardless, only overflow_irq is gated
// R24: without toggle-on-overflow the pin never toggles at overflow
// R25: counter returns to zero on the increment after modulo
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "cctmr_consts.svh"
module cctmr_timer
#(
  parameter int NUM_CH = 4
)
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external count clock
  input wire logic external_count_clock_pin,
  // channel pins
  input wire logic [NUM_CH-1:0] channel_pin_in,
  output logic [NUM_CH-1:0] channel_pin_out,
  output logic [NUM_CH-1:0] channel_pin_oe,
  // interrupt requests
  output logic overflow_irq,
  output logic [NUM_CH-1:0] channel_irq
);
  // pair linking is hard-wired to channels 0/1 and 2/3, so exactly four fit
  if (NUM_CH != 4)
  begin : g_num_ch_check
    $error("four channels required for pair linking");
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] tsc_r;
  cctmr_pkg::cctmr_count_t cnt_r;
  cctmr_pkg::cctmr_count_t mod_r;
  cctmr_pkg::cctmr_chctl_s csc_r [NUM_CH];
  cctmr_pkg::cctmr_count_t chv_r [NUM_CH];
  logic [NUM_CH-1:0] pin_r;
  logic [NUM_CH-1:0] pin_d_r;
  logic [1:0] act_r;
  logic [1:0] last_r;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  // 0x00 status/control: prescale select, counter reset strobe, stop,
  //      overflow enable and overflow flag (writing zero clears it)
  // 0x04/0x08 count high/low: read only, a write is accepted and dropped
  // 0x0c/0x10 modulo high/low: all ones after reset, so the count runs free
  // channel n at 0x20 + 0x10*n: control, value high at +4, value low at +8
  // only bits 7:0 of each word carry data; the rest read as zero
  // bytes are written one at a time, so a 16-bit value needs two writes
  // and a compare may briefly see the half-written value
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire in_ch = (paddr >= `CCTMR_OFS_CH_BASE) && (paddr < 12'h060);
  wire [11:0] ch_off = paddr - `CCTMR_OFS_CH_BASE;
  wire [1:0] ch_sel = ch_off[5:4];
  // channel window: the stride picks the channel, the low nibble the word
  wire [11:0] ch_reg = {8'h00, ch_off[3:0]};
  wire hit_tsc = paddr == `CCTMR_OFS_STATUS_CONTROL;
  wire hit_cnth = paddr == `CCTMR_OFS_COUNT_HIGH;
  wire hit_cntl = paddr == `CCTMR_OFS_COUNT_LOW;
  wire hit_modh = paddr == `CCTMR_OFS_MODULO_HIGH;
  wire hit_modl = paddr == `CCTMR_OFS_MODULO_LOW;
  wire hit_cc = in_ch && ch_reg == `CCTMR_OFS_CH_CTRL;
  wire hit_ch = in_ch && ch_reg == `CCTMR_OFS_CH_HIGH;
  wire hit_cl = in_ch && ch_reg == `CCTMR_OFS_CH_LOW;
  // anything else, holes in the channel window included, is unmapped
  wire mapped = hit_tsc | hit_cnth | hit_cntl | hit_modh | hit_modl
              | hit_cc | hit_ch | hit_cl;
  // zero wait state slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  ////////////////////////////////////////////////////////////////////////
  // counter
  wire [2:0] prescale_select = tsc_r[`CCTMR_TSC_PS_LSB +: 3];
  // stop freezes counter and compares; the prescaler keeps running
  wire stop = tsc_r[`CCTMR_TSC_STOP_BIT];
  // the reset bit is a strobe, never stored, so it always reads back zero
  wire rst_req = wr & hit_tsc & pwdata[`CCTMR_TSC_RST_BIT];
  // prescaler clears with the counter so a restart begins a whole period
  wire tick;
  cctmr_tick_if tk ();
  assign tk.prescale_select = prescale_select; // R5 R6
  assign tk.ext_level = external_count_clock_pin;
  assign tk.clear = rst_req;
  assign tick = tk.tick;
  // divider and external edge detector live in their own module
  cctmr_prescaler u_pre
  (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );
  // overflow and increment only on a tick while running
  wire at_mod = cnt_r == mod_r;
  wire ovf = tick & ~stop & at_mod; // R23
  wire inc = tick & ~stop;
  // modulo of all ones makes it free running; the reset strobe beats a tick,
  // and a tick at the modulo value wraps to zero instead of counting on
  wire [15:0] cnt_nxt = rst_req ? 16'h0000 : ovf ? 16'h0000 // R25
                      : inc ? cnt_r + 16'h0001 : cnt_r; // R1

  ////////////////////////////////////////////////////////////////////////
  // buffered pair links
  wire [1:0] link = {csc_r[2].msb, csc_r[0].msb}; // R14 R18

  ////////////////////////////////////////////////////////////////////////
  // per channel logic
  // events, compares and next pin levels gathered as vectors for the flops
  logic [NUM_CH-1:0] ev;
  logic [NUM_CH-1:0] cmp;
  logic [NUM_CH-1:0] out_nxt;
  logic [NUM_CH-1:0] is_cap;
  logic [NUM_CH-1:0] vwr;
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_ch
      localparam int P = c / 2;
      localparam bit EVEN = (c % 2) == 0;
      wire linked = link[P];
      // the odd channel of a linked pair gives its pin back to general use
      wire freed = linked & ~EVEN; // R17
      // every channel runs on its own control; a linked pair runs on the
      // even one, and the odd control is ignored while freed
      cctmr_pkg::cctmr_chctl_s cfg;
      assign cfg = csc_r[c];
      // mode and edge select fields of that control
      wire [1:0] mode = {cfg.msb, cfg.msa};
      wire [1:0] edge_sel = {cfg.elsb, cfg.elsa};
      // capture wants mode 00 and some edge; linked or freed never captures
      wire cap = ~freed & ~linked & mode == 2'b00 & edge_sel != 2'b00; // R4
      assign is_cap[c] = cap;
      // pin edges against last cycle's level; both idle low after reset
      wire rise = channel_pin_in[c] & ~pin_d_r[c];
      wire fall = ~channel_pin_in[c] & pin_d_r[c];
      wire act_edge = (edge_sel == 2'b01 & rise) | (edge_sel == 2'b10 & fall)
                    | (edge_sel == 2'b11 & (rise | fall)); // R8
      // linked pair compares against whichever channel is active; the index
      // comes from the pair number, so it cannot leave the array
      wire [1:0] pick = {P[0], act_r[P]};
      wire [15:0] cval = linked ? chv_r[pick] : chv_r[c]; // R16
      // compare owns the pin when linked or in a mode other than 00, unless freed or the edge select is off
      wire cmp_en = ~freed & (linked | mode != 2'b00) & edge_sel != 2'b00;
      wire match = tick & ~stop & cnt_r == cval;
      assign cmp[c] = cmp_en & match;
      assign ev[c] = cap ? act_edge : cmp[c]; // R9 R11
      // overflow toggle first; a compare on the same tick overrides it
      logic o;
      always_comb
      begin
        o = pin_r[c];
        if (ovf & cmp_en & cfg.tov) // R20 R24
          o = ~o;
        if (cmp[c])
        begin
          unique case (edge_sel) // R10
            2'b01: o = ~pin_r[c];
            2'b10: o = 1'b0;
            2'b11: o = 1'b1;
            default: o = pin_r[c];
          endcase
        end
        // max duty, with toggle on overflow set, holds the pin high through the compare
        if (cmp[c] & cfg.tov & cfg.maxd)
          o = 1'b1;
      end
      assign out_nxt[c] = o;
      assign channel_pin_out[c] = pin_r[c];
      assign channel_pin_oe[c] = cmp_en;
      assign channel_irq[c] = csc_r[c].flag & csc_r[c].ie;
    end
  endgenerate

  // requests are plain levels: flag and enable
  assign overflow_irq = tsc_r[`CCTMR_TSC_OVF_BIT] & tsc_r[`CCTMR_TSC_OIE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // channel value write strobes; capture wins over a software write
  wire csc_wr = wr & hit_cc;
  wire [3:0] ch_hit = 4'h1 << ch_sel;
  assign vwr = {4{wr & (hit_ch | hit_cl)}} & ch_hit;

  // overflow flag: set wins over clear
  wire [7:0] tsc_wd = pwdata[7:0];
  wire ovf_clr = wr & hit_tsc & ~tsc_wd[`CCTMR_TSC_OVF_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tsc_r <= `CCTMR_TSC_RESET;
      cnt_r <= 16'h0000;
      mod_r <= `CCTMR_MOD_RESET;
      pin_r <= 4'h0;
      pin_d_r <= 4'h0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      pin_r <= out_nxt;
      pin_d_r <= channel_pin_in;
      if (wr & hit_tsc)
        tsc_r <= {1'b0, tsc_wd[6:5], 1'b0, 1'b0, tsc_wd[2:0]};
      // flag set beats a clearing write in the same cycle
      if (ovf | (tsc_r[`CCTMR_TSC_OVF_BIT] & ~ovf_clr))
        tsc_r[`CCTMR_TSC_OVF_BIT] <= 1'b1;
      else if (ovf_clr)
        tsc_r[`CCTMR_TSC_OVF_BIT] <= 1'b0;
      if (wr & hit_modh) // R2
        mod_r[15:8] <= pwdata[7:0];
      if (wr & hit_modl)
        mod_r[7:0] <= pwdata[7:0];
    end
  end

  // channel control and values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        csc_r[i] <= '0;
        chv_r[i] <= 16'h0000;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        // an event in the cycle of a clearing write still sets the flag
        if (csc_wr && ch_sel == 2'(i))
        begin
          csc_r[i] <= pwdata[7:0];
          csc_r[i].flag <= ev[i] | (csc_r[i].flag & pwdata[7]);
        end
        else if (ev[i])
          csc_r[i].flag <= 1'b1;
        if (vwr[i] & hit_ch) // R12
          chv_r[i][15:8] <= pwdata[7:0];
        if (vwr[i] & hit_cl)
          chv_r[i][7:0] <= pwdata[7:0];
        // a capture on the edge of a software value write wins
        if (ev[i] & is_cap[i]) // R7
          chv_r[i] <= cnt_r;
      end
    end
  end

  // active channel of each pair, swapped only at overflow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_r <= 2'b00;
      last_r <= 2'b00;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        // leaving buffered mode forgets the history, a relink starts even
        if (!link[p])
        begin
          act_r[p] <= 1'b0;
          last_r[p] <= 1'b0;
        end
        else
        begin
          // writing the active channel acts at once, as an unbuffered update
          if (vwr[2*p+1]) // R15
            last_r[p] <= 1'b1;
          else if (vwr[2*p])
            last_r[p] <= 1'b0;
          // the swap waits for overflow so a period is never cut short
          if (ovf) // R16
            act_r[p] <= last_r[p];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; counter reads only look, never latch or reset (R3)
  // a freed channel's registers still read back as written
  wire [15:0] ch_rd = chv_r[ch_sel];
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd)
    begin
      if (hit_tsc)
        prdata = {24'h00_0000, tsc_r};
      else if (hit_cnth)
        prdata = {24'h00_0000, cnt_r[15:8]}; // R3
      else if (hit_cntl)
        prdata = {24'h00_0000, cnt_r[7:0]};
      else if (hit_modh)
        prdata = {24'h00_0000, mod_r[15:8]};
      else if (hit_modl)
        prdata = {24'h00_0000, mod_r[7:0]};
      else if (hit_cc)
        prdata = {24'h00_0000, csc_r[ch_sel]};
      else if (hit_ch)
        prdata = {24'h00_0000, ch_rd[15:8]};
      else if (hit_cl)
        prdata = {24'h00_0000, ch_rd[7:0]};
    end
  end
endmodule

//--- cctmr_consts.svh
`ifndef CCTMR_CONSTS_SVH
`define CCTMR_CONSTS_SVH
// register byte offsets
`define CCTMR_OFS_STATUS_CONTROL 12'h000
`define CCTMR_OFS_COUNT_HIGH 12'h004
`define CCTMR_OFS_COUNT_LOW 12'h008
`define CCTMR_OFS_MODULO_HIGH 12'h00C
`define CCTMR_OFS_MODULO_LOW 12'h010
`define CCTMR_OFS_CH_BASE 12'h020
`define CCTMR_OFS_CH_STRIDE 12'h010
`define CCTMR_OFS_CH_CTRL 12'h000
`define CCTMR_OFS_CH_HIGH 12'h004
`define CCTMR_OFS_CH_LOW 12'h008
// timer status/control field positions
`define CCTMR_TSC_PS_LSB 0
`define CCTMR_TSC_RST_BIT 4
`define CCTMR_TSC_STOP_BIT 5
`define CCTMR_TSC_OIE_BIT 6
`define CCTMR_TSC_OVF_BIT 7
// channel status/control field positions
`define CCTMR_CSC_TOV_BIT 0
`define CCTMR_CSC_ELSA_BIT 2
`define CCTMR_CSC_ELSB_BIT 3
`define CCTMR_CSC_MSA_BIT 4
`define CCTMR_CSC_MSB_BIT 5
`define CCTMR_CSC_IE_BIT 6
`define CCTMR_CSC_FLAG_BIT 7
// reset values and the external prescale code
`define CCTMR_TSC_RESET 8'h20
`define CCTMR_MOD_RESET 16'hFFFF
`define CCTMR_PS_EXT 3'h7
`endif

//--- cctmr_pkg.sv
package cctmr_pkg;
  typedef logic [15:0] cctmr_count_t;
  typedef struct packed
  {
    logic flag;
    logic ie;
    logic msb;
    logic msa;
    logic elsb;
    logic elsa;
    logic maxd;
    logic tov;
  } cctmr_chctl_s;
endpackage

//--- cctmr_tick_if.sv
`timescale 1ns/1ns
interface cctmr_tick_if;
  logic [2:0] prescale_select;
  logic ext_level;
  logic clear;
  logic tick;
  modport ctrl (output prescale_select, output ext_level, output clear, input tick);
  modport gen (input prescale_select, input ext_level, input clear, output tick);
endinterface

//--- cctmr_prescaler.sv
`timescale 1ns/1ns
`include "cctmr_consts.svh"
module cctmr_prescaler
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // selection and tick
  cctmr_tick_if.gen tk
);
  logic [5:0] div_r;
  logic ext_d_r;
  logic [6:0] rate_tick;
  logic ext_rise;

  // each rate fires when the low bits of the divider are all ones
  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : g_rate
      if (g == 0)
      begin : g_bus
        assign rate_tick[g] = 1'b1;
      end
      else
      begin : g_div
        assign rate_tick[g] = &div_r[g-1:0];
      end
    end
  endgenerate
  assign ext_rise = tk.ext_level & ~ext_d_r;
  // external pin picked by code 7; limited to half the bus rate by sampling
  assign tk.tick = (tk.prescale_select == `CCTMR_PS_EXT) ? ext_rise
                 : rate_tick[tk.prescale_select];

  // divider, cleared together with the counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_r <= 6'h00;
      ext_d_r <= 1'b0;
    end
    else
    begin
      div_r <= tk.clear ? 6'h00 : div_r + 6'h01;
      ext_d_r <= tk.ext_level;
    end
  end
endmodule

//--- cctmr_timer_properties.sv
`timescale 1ns/1ns
module cctmr_timer_properties
#(
  parameter int NUM_CH = 4
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and requests
  input wire logic external_count_clock_pin,
  input wire logic [NUM_CH-1:0] channel_pin_in,
  input wire logic [NUM_CH-1:0] channel_pin_out,
  input wire logic [NUM_CH-1:0] channel_pin_oe,
  input wire logic overflow_irq,
  input wire logic [NUM_CH-1:0] channel_irq
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // access decodes; flags may only drop on a software write
  wire acc = psel && penable;
  wire wr_tsc = acc && pwrite && paddr == 12'h000;
  wire wr_ch = acc && pwrite && paddr >= 12'h020;
  ////////////////////////////////////////
  pready_high_a: assert property (pready)
    else $error("ready low");
  rd_idle_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("read data outside read");
  slverr_phase_a: assert property (pslverr |-> acc)
    else $error("error outside access");
  mapped_ok_a: assert property (acc && paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped register");
  ovf_hold_a: assert property (overflow_irq && !wr_tsc |=> overflow_irq)
    else $error("overflow request dropped");
  ovf_fall_a: assert property ($fell(overflow_irq) |-> $past(wr_tsc))
    else $error("overflow request fell unbidden");
  ch_fall_a: assert property (|($past(channel_irq) & ~channel_irq) |-> $past(wr_ch))
    else $error("channel request fell unbidden");
  reset_quiet_a: assert property ($rose(presetn) |-> channel_pin_oe == '0 && !overflow_irq)
    else $error("outputs busy after reset");
  // main scenarios reached
  cover property ($rose(overflow_irq));
  cover property ($rose(channel_irq[1]));
  cover property (pslverr);
  cover property ($rose(channel_pin_out[0]));
endmodule

bind cctmr_timer cctmr_timer_properties #(.NUM_CH(NUM_CH)) cctmr_timer_properties_i
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_count_clock_pin(external_count_clock_pin), .channel_pin_in(channel_pin_in),
  .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
  .overflow_irq(overflow_irq), .channel_irq(channel_irq)
);

//--- cctmr_pin_model.sv
`timescale 1ns/1ns
module cctmr_pin_model
(
  // clock
  input wire logic pclk,
  // device side of the pins
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_in
);
  logic [3:0] drv_r = 4'h0;
  // an enabled pin shows the device, a free one the event source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_r);
  // source edges move just after a clock edge
  task automatic drive(input int n, input logic v);
    @(posedge pclk);
    drv_r[n] <= v;
  endtask
  // load side: cycles the pin sits high
  task automatic measure(input int n, input int cyc, output int hi);
    hi = 0;
    repeat (cyc)
    begin
      @(posedge pclk);
      hi += int'(pin_in[n] === 1'b1);
    end
  endtask
endmodule

//--- cctmr_timer_tb.sv
`timescale 1ns/1ns
module cctmr_timer_tb;
  logic pclk, presetn, psel, penable, pwrite, ext_clk, pready, pslverr, ovf_irq, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, c0, c1;
  logic [3:0] pin_in, pin_out, pin_oe, ch_irq;
  localparam logic [31:0] zero = 32'h0000_0000;
  int err_count = 0;
  int n_compared = 0;
  int h;
  // 100 MHz bus clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  cctmr_timer cctmr_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_clock_pin(ext_clk), .channel_pin_in(pin_in),
    .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .overflow_irq(ovf_irq),
    .channel_irq(ch_irq));
  cctmr_pin_model cctmr_pin_model_i (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));
  ////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_count++;
      stop_test();
    end
  endtask
  // bounded wait on a request line, negative selects overflow
  task automatic wait_irq(input int b);
    int k;
    k = 0;
    while (((b < 0) ? ovf_irq : ch_irq[b]) !== 1'b1 && k < 200)
    begin
      @(negedge pclk);
      k++;
    end
    if (k >= 200)
    begin
      err_count++;
      stop_test();
    end
  endtask
  // pulse width over four whole periods of sixteen
  task automatic pw(input int n, input int lo, input int hi);
    repeat (32) @(posedge pclk);
    cctmr_pin_model_i.measure(n, 64, h);
    chk_rng(h, lo, hi);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, 12'h000, zero);
    chk(rd, 32'h0000_0020);
    apb(1'b0, 12'h010, zero);
    chk(rd, 32'h0000_00FF);
    apb(1'b0, 12'h0FC, zero);
    chk({rd[30:0], last_err}, 32'h0000_0001);
    $display("test reset done");
  endtask
  task automatic t_prescale();
    apb(1'b1, 12'h000, 32'h0000_0010);
    apb(1'b0, 12'h008, zero);
    c0 = rd;
    apb(1'b0, 12'h008, zero);
    chk((rd - c0) & 32'h0000_00FF, 32'h0000_0003);
    apb(1'b1, 12'h000, 32'h0000_0007);
    apb(1'b0, 12'h008, zero);
    c0 = rd;
    apb(1'b0, 12'h008, zero);
    chk(rd, c0);
    ext_clk <= 1'b1;
    repeat (3) @(posedge pclk);
    ext_clk <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h008, zero);
    chk((rd - c0) & 32'h0000_00FF, 32'h0000_0001);
    $display("test prescale done");
  endtask
  task automatic t_wrap();
    apb(1'b1, 12'h00C, zero);
    apb(1'b1, 12'h010, 32'h0000_0005);
    apb(1'b1, 12'h000, 32'h0000_0050);
    wait_irq(-1);
    repeat (4)
    begin
      apb(1'b0, 12'h008, zero);
      chk_rng(rd, zero, 32'h0000_0005);
    end
    apb(1'b1, 12'h000, zero);
    @(negedge pclk);
    chk(ovf_irq, 1'b0);
    $display("test wrap done");
  endtask
  task automatic t_capture();
    apb(1'b1, 12'h00C, 32'h0000_00FF);
    apb(1'b1, 12'h010, 32'h0000_00FF);
    apb(1'b1, 12'h000, 32'h0000_0010);
    apb(1'b1, 12'h030, 32'h0000_0044);
    apb(1'b0, 12'h008, zero);
    c0 = rd;
    cctmr_pin_model_i.drive(1, 1'b1);
    wait_irq(1);
    apb(1'b0, 12'h038, zero);
    c1 = rd;
    apb(1'b0, 12'h008, zero);
    chk_rng(c1, c0, rd);
    apb(1'b1, 12'h030, 32'h0000_0044);
    cctmr_pin_model_i.drive(1, 1'b0);
    repeat (8) @(negedge pclk);
    chk(ch_irq[1], 1'b0);
    $display("test capture done");
  endtask
  task automatic t_pwm(input int n);
    logic [11:0] b;
    b = 12'h020 + 12'(16 * n);
    apb(1'b1, 12'h000, 32'h0000_0030);
    apb(1'b1, 12'h00C, zero);
    apb(1'b1, 12'h010, 32'h0000_000F);
    apb(1'b1, b + 12'h004, zero);
    apb(1'b1, b + 12'h008, 32'h0000_0008);
    apb(1'b1, b, 32'h0000_0019);
    apb(1'b1, 12'h000, zero);
    pw(n, 32, 40);
    chk(pin_oe[n], 1'b1);
    apb(1'b1, b, 32'h0000_0059);
    wait_irq(n);
    apb(1'b1, b + 12'h008, 32'h0000_0004);
    pw(n, 16, 24);
    apb(1'b1, b, 32'h0000_0018);
    apb(1'b1, b + 12'h010, 32'h0000_0018);
    pw(n, 0, 0);
    chk(pin_oe[n + 1], 1'b1);
    apb(1'b1, b, 32'h0000_0029);
    apb(1'b1, b + 12'h008, 32'h0000_0004);
    pw(n, 16, 24);
    apb(1'b1, b + 12'h014, zero);
    apb(1'b1, b + 12'h018, 32'h0000_000C);
    pw(n, 48, 56);
    chk(pin_oe[n + 1], 1'b0);
    apb(1'b1, b + 12'h008, 32'h0000_0006);
    pw(n, 24, 32);
    apb(1'b1, b, zero);
    $display("test pwm pair %0d done", n);
  endtask
  ////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = zero;
    ext_clk = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_prescale();
    t_wrap();
    t_capture();
    t_pwm(0);
    t_pwm(2);
    stop_test();
  end
endmodule
